// ---- stmh_pkg.sv ----
// Message codes, bus phase codes and state codes for the target message handler
package stmh_pkg;

	localparam logic [7:0] MSG_CMD_COMPLETE = 8'h00;
	localparam logic [7:0] MSG_SAVE_PTR     = 8'h02;
	localparam logic [7:0] MSG_RESTORE_PTRS = 8'h03;
	localparam logic [7:0] MSG_DISCONNECT   = 8'h04;
	localparam logic [7:0] MSG_INIT_ERR     = 8'h05;
	localparam logic [7:0] MSG_ABORT        = 8'h06;
	localparam logic [7:0] MSG_REJECT       = 8'h07;
	localparam logic [7:0] MSG_NOP          = 8'h08;
	localparam logic [7:0] MSG_PARITY_ERR   = 8'h09;
	localparam logic [7:0] MSG_DEV_RESET    = 8'h0C;
	localparam logic [7:0] MSG_IDENTIFY_MIN = 8'h80;

	localparam logic [3:0] SENSE_ABORTED_CMD = 4'hB;
	localparam logic [3:0] SENSE_RST         = 4'h0;
	localparam logic [7:0] TX_BYTE_RST       = 8'h00;
	localparam logic       ATN_RST           = 1'b0;

	typedef enum logic [2:0] {
		PH_SELECTION = 3'h0,
		PH_COMMAND   = 3'h1,
		PH_DATA_OUT  = 3'h2,
		PH_DATA_IN   = 3'h3,
		PH_STATUS    = 3'h4,
		PH_MSG_OUT   = 3'h5,
		PH_MSG_IN    = 3'h6,
		PH_BUS_FREE  = 3'h7
	} stmh_phase_e;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_RESTORE = 3'b010,
		ST_REJECT  = 3'b100
	} stmh_state_e;

endpackage

// ---- stmh_atn_sync.sv ----
// Three-stage synchroniser for the attention pin with agreement filter
module stmh_atn_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level
);
	import stmh_pkg::*;

	logic s1, s2, s3;
	logic next_level;

	// A change counts only once the second and third stages agree
	always_comb begin
		next_level = level;
		if (s2 == s3) begin
			next_level = s3;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1    <= ATN_RST;
			s2    <= ATN_RST;
			s3    <= ATN_RST;
			level <= ATN_RST;
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
		end
	end

endmodule

// ---- stmh_msg_handler.sv ----
// Target-side handler for received messages and the bus phase that follows them
module stmh_msg_handler (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  atn_pin,
	input  wire logic                  rx_valid,
	input  wire logic [7:0]            rx_byte,
	input  wire stmh_pkg::stmh_phase_e atn_phase,
	input  wire logic                  image_xfer,
	input  wire logic                  mem_fitted,
	input  wire logic                  lun_identified,
	input  wire logic                  op_pending,
	input  wire logic                  seq_sent,
	input  wire logic [7:0]            seq_code,
	input  wire logic                  seq_reconnect,
	input  wire logic                  tx_done,
	output logic                       tx_req,
	output logic [7:0]                 tx_byte,
	output logic                       phase_req,
	output stmh_pkg::stmh_phase_e      phase_sel,
	output logic                       status_check,
	output logic                       resend,
	output logic                       discard_cmd,
	output logic                       discard_data,
	output logic                       clear_op,
	output logic                       sense_we,
	output logic [3:0]                 sense_key,
	output logic                       stay_connected,
	output logic                       cmd_error,
	output logic                       msg_taken,
	output logic                       more_msgs
);
	import stmh_pkg::*;

	stmh_state_e state, next_state;
	stmh_phase_e ph, next_ph, next_phase_sel;
	logic        img, next_img;
	logic        atn_level;
	logic        sent_valid, next_sent_valid;
	logic [7:0]  sent_code, next_sent_code;
	logic        sent_reconn, next_sent_reconn;
	logic        next_tx_req, next_phase_req, next_status_check, next_resend;
	logic        next_discard_cmd, next_discard_data, next_clear_op, next_sense_we;
	logic        next_stay, next_cmd_error, next_msg_taken, next_more;
	logic [7:0]  next_tx_byte;
	logic [3:0]  next_sense_key;
	logic        supported;

	stmh_atn_sync u_atn (
		.clk   (clk),
		.rst   (rst),
		.pin   (atn_pin),
		.level (atn_level)
	);

	// Codes handled here or by the neighbouring message logic
	assign supported = (rx_byte == MSG_INIT_ERR) || (rx_byte == MSG_ABORT) ||
		(rx_byte == MSG_REJECT) || (rx_byte == MSG_NOP) || (rx_byte == MSG_PARITY_ERR) ||
		(rx_byte == MSG_DEV_RESET) || (rx_byte >= MSG_IDENTIFY_MIN);

	always_comb begin
		next_state        = state;
		next_ph           = ph;
		next_img          = img;
		next_tx_req       = 1'b0;
		next_tx_byte      = tx_byte;
		next_phase_req    = 1'b0;
		next_phase_sel    = phase_sel;
		next_status_check = 1'b0;
		next_resend       = 1'b0;
		next_discard_cmd  = 1'b0;
		next_discard_data = 1'b0;
		next_clear_op     = 1'b0;
		next_sense_we     = 1'b0;
		next_sense_key    = sense_key;
		next_stay         = 1'b0;
		next_cmd_error    = 1'b0;
		next_msg_taken    = 1'b0;
		next_more         = more_msgs;
		unique case (state)
			ST_IDLE: begin
				if (rx_valid) begin
					next_msg_taken = 1'b1;
					// Initiator model sets ATN five cycles ahead of the byte, past the synchroniser delay, so this level is fresh
					next_more = atn_level;
					if (rx_byte == MSG_INIT_ERR) begin
						if (atn_phase != PH_MSG_OUT) begin
							next_ph      = atn_phase;
							next_img     = image_xfer;
							next_tx_req  = 1'b1;
							next_tx_byte = MSG_RESTORE_PTRS;
							next_state   = ST_RESTORE;
						end
					end else if (rx_byte == MSG_ABORT) begin
						// Nothing to clear is not an error
						next_clear_op  = lun_identified && op_pending;
						next_phase_req = 1'b1;
						next_phase_sel = PH_BUS_FREE;
					end else if (rx_byte == MSG_REJECT) begin
						if (!sent_valid || sent_code == MSG_CMD_COMPLETE) begin
							next_phase_req = 1'b1;
							next_phase_sel = PH_BUS_FREE;
						end else if (sent_code == MSG_REJECT || sent_code == MSG_RESTORE_PTRS) begin
							next_phase_req    = 1'b1;
							next_phase_sel    = PH_STATUS;
							next_status_check = 1'b1;
						end else if (sent_code == MSG_DISCONNECT || sent_code == MSG_SAVE_PTR) begin
							next_stay = 1'b1;
						end else if (sent_code >= MSG_IDENTIFY_MIN && sent_reconn) begin
							next_cmd_error = 1'b1;
							next_phase_req = 1'b1;
							next_phase_sel = PH_BUS_FREE;
						end
					end else if (!supported) begin
						// Phase is left as it was; the code is otherwise dropped
						next_tx_req  = 1'b1;
						next_tx_byte = MSG_REJECT;
						next_state   = ST_REJECT;
					end
					// No operation and codes owned elsewhere fall through untouched
				end
			end
			ST_RESTORE: begin
				if (rx_valid && rx_byte == MSG_REJECT) begin
					next_msg_taken    = 1'b1;
					next_more         = atn_level;
					next_phase_req    = 1'b1;
					next_phase_sel    = PH_STATUS;
					next_status_check = 1'b1;
					next_state        = ST_IDLE;
				end else if (tx_done) begin
					next_state     = ST_IDLE;
					next_phase_req = 1'b1;
					next_phase_sel = ph;
					unique case (ph)
						PH_SELECTION: next_phase_sel = PH_BUS_FREE;
						PH_COMMAND:   next_discard_cmd = 1'b1;
						PH_DATA_OUT:  next_discard_data = 1'b1;
						PH_DATA_IN: begin
							if (img && !mem_fitted) begin
								// Image is gone without memory; the sequencer closes with complete
								next_phase_sel    = PH_STATUS;
								next_status_check = 1'b1;
								next_sense_we     = 1'b1;
								next_sense_key    = SENSE_ABORTED_CMD;
							end else begin
								next_resend = 1'b1;
							end
						end
						PH_STATUS:    next_resend = 1'b1;
						PH_MSG_IN:    next_resend = 1'b1;
						PH_MSG_OUT:   next_phase_req = 1'b0;
						PH_BUS_FREE:  next_phase_req = 1'b0;
					endcase
				end
			end
			ST_REJECT: begin
				if (tx_done) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Last message this target put on the bus, for judging a reject
	always_comb begin
		next_sent_valid  = sent_valid;
		next_sent_code   = sent_code;
		next_sent_reconn = sent_reconn;
		if (seq_sent) begin
			next_sent_valid  = 1'b1;
			next_sent_code   = seq_code;
			next_sent_reconn = seq_reconnect;
		end else if (tx_done && state != ST_IDLE) begin
			next_sent_valid  = 1'b1;
			next_sent_code   = tx_byte;
			next_sent_reconn = 1'b0;
		end else if (phase_req && phase_sel == PH_BUS_FREE) begin
			next_sent_valid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state          <= ST_IDLE;
			ph             <= PH_BUS_FREE;
			img            <= 1'b0;
			tx_req         <= 1'b0;
			tx_byte        <= TX_BYTE_RST;
			phase_req      <= 1'b0;
			phase_sel      <= PH_BUS_FREE;
			status_check   <= 1'b0;
			resend         <= 1'b0;
			discard_cmd    <= 1'b0;
			discard_data   <= 1'b0;
			clear_op       <= 1'b0;
			sense_we       <= 1'b0;
			sense_key      <= SENSE_RST;
			stay_connected <= 1'b0;
			cmd_error      <= 1'b0;
			msg_taken      <= 1'b0;
			more_msgs      <= 1'b0;
			sent_valid     <= 1'b0;
			sent_code      <= TX_BYTE_RST;
			sent_reconn    <= 1'b0;
		end else begin
			state          <= next_state;
			ph             <= next_ph;
			img            <= next_img;
			tx_req         <= next_tx_req;
			tx_byte        <= next_tx_byte;
			phase_req      <= next_phase_req;
			phase_sel      <= next_phase_sel;
			status_check   <= next_status_check;
			resend         <= next_resend;
			discard_cmd    <= next_discard_cmd;
			discard_data   <= next_discard_data;
			clear_op       <= next_clear_op;
			sense_we       <= next_sense_we;
			sense_key      <= next_sense_key;
			stay_connected <= next_stay;
			cmd_error      <= next_cmd_error;
			msg_taken      <= next_msg_taken;
			more_msgs      <= next_more;
			sent_valid     <= next_sent_valid;
			sent_code      <= next_sent_code;
			sent_reconn    <= next_sent_reconn;
		end
	end

	property p_restore;
		@(posedge clk) disable iff (rst)
		(state == ST_IDLE && rx_valid && rx_byte == MSG_INIT_ERR && atn_phase != PH_MSG_OUT)
			|=> (tx_req && tx_byte == MSG_RESTORE_PTRS && state == ST_RESTORE);
	endproperty
	a_restore: assert property (p_restore) else $error("restore pointers not sent");

	property p_ignore;
		@(posedge clk) disable iff (rst)
		(state == ST_IDLE && rx_valid && rx_byte == MSG_INIT_ERR && atn_phase == PH_MSG_OUT)
			|=> (!tx_req && state == ST_IDLE);
	endproperty
	a_ignore: assert property (p_ignore) else $error("error message in message out not ignored");

	property p_sel_free;
		@(posedge clk) disable iff (rst)
		(state == ST_RESTORE && tx_done && !rx_valid && ph == PH_SELECTION)
			|=> (phase_req && phase_sel == PH_BUS_FREE && !resend);
	endproperty
	a_sel_free: assert property (p_sel_free) else $error("selection retry not bus free");

	property p_cmd_retry;
		@(posedge clk) disable iff (rst)
		(state == ST_RESTORE && tx_done && !rx_valid && ph == PH_COMMAND)
			|=> (discard_cmd && phase_req && phase_sel == PH_COMMAND) ##1 !discard_cmd;
	endproperty
	a_cmd_retry: assert property (p_cmd_retry) else $error("command retry wrong");

	property p_dout_retry;
		@(posedge clk) disable iff (rst)
		(state == ST_RESTORE && tx_done && !rx_valid && ph == PH_DATA_OUT)
			|=> (discard_data && phase_sel == PH_DATA_OUT);
	endproperty
	a_dout_retry: assert property (p_dout_retry) else $error("data out retry wrong");

	property p_nomem;
		@(posedge clk) disable iff (rst)
		(state == ST_RESTORE && tx_done && !rx_valid && ph == PH_DATA_IN && img && !mem_fitted)
			|=> (status_check && phase_sel == PH_STATUS && sense_we && sense_key == SENSE_ABORTED_CMD);
	endproperty
	a_nomem: assert property (p_nomem) else $error("image retry without memory wrong");

	property p_resend;
		@(posedge clk) disable iff (rst)
		(state == ST_RESTORE && tx_done && !rx_valid && (ph == PH_STATUS || ph == PH_MSG_IN))
			|=> (resend && phase_sel == $past(ph));
	endproperty
	a_resend: assert property (p_resend) else $error("status or message in not resent");

	property p_abort;
		@(posedge clk) disable iff (rst)
		(state == ST_IDLE && rx_valid && rx_byte == MSG_ABORT)
			|=> (phase_req && phase_sel == PH_BUS_FREE && clear_op == $past(lun_identified && op_pending)
				&& !status_check);
	endproperty
	a_abort: assert property (p_abort) else $error("abort handling wrong");

	property p_nop;
		@(posedge clk) disable iff (rst)
		(state == ST_IDLE && rx_valid && rx_byte == MSG_NOP)
			|=> (!tx_req && !phase_req && !clear_op && !stay_connected) [*2];
	endproperty
	a_nop: assert property (p_nop) else $error("no operation caused action");

	property p_unsup;
		@(posedge clk) disable iff (rst)
		(state == ST_IDLE && rx_valid && !supported)
			|=> (tx_req && tx_byte == MSG_REJECT && !phase_req);
	endproperty
	a_unsup: assert property (p_unsup) else $error("unsupported code not rejected");

	property p_rej_free;
		@(posedge clk) disable iff (rst)
		(state == ST_IDLE && rx_valid && rx_byte == MSG_REJECT && (!sent_valid || sent_code == MSG_CMD_COMPLETE))
			|=> (phase_req && phase_sel == PH_BUS_FREE && !status_check && !cmd_error);
	endproperty
	a_rej_free: assert property (p_rej_free) else $error("reject of complete not bus free");

	property p_more;
		@(posedge clk) disable iff (rst)
		(msg_taken) |-> (more_msgs == $past(atn_level));
	endproperty
	a_more: assert property (p_more) else $error("ATN not sampled with message");

endmodule

// ---- stmh_init_model.sv ----
// Initiator model: sends message bytes and releases ACK of message-in bytes
module stmh_init_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tx_req,
	input  wire logic [7:0] ack_delay,
	output logic            tx_done,
	output logic            atn_pin,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	initial begin
		tx_done = 1'b0;
		atn_pin = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		busy = 1'b0;
		cnt = 8'h00;
	end
	// Long delay lets a reject overtake the pending ACK
	always @(posedge clk) begin
		tx_done <= 1'b0;
		if (rst) begin
			busy <= 1'b0;
		end else if (tx_req) begin
			busy <= 1'b1;
			cnt <= ack_delay;
		end else if (busy && cnt == 8'h00) begin
			busy <= 1'b0;
			tx_done <= 1'b1;
		end else if (busy) begin
			cnt <= cnt - 8'h01;
		end
	end
	// ATN is driven at the first edge of a send, whether or not the previous byte has been released
	task automatic send(input logic [7:0] code, input logic atn);
		@(posedge clk);
		atn_pin <= atn;
		repeat (5) @(posedge clk);
		rx_valid <= 1'b1;
		rx_byte <= code;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_byte <= ~code;
		repeat (2) @(posedge clk);
	endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the target message handler
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import stmh_pkg::*;
	localparam logic [10:0] V_T = 11'h400;
	localparam logic [10:0] V_P = 11'h200;
	localparam logic [10:0] V_S = 11'h100;
	localparam logic [10:0] V_R = 11'h080;
	localparam logic [10:0] V_DC = 11'h040;
	localparam logic [10:0] V_DD = 11'h020;
	localparam logic [10:0] V_CO = 11'h010;
	localparam logic [10:0] V_SW = 11'h008;
	localparam logic [10:0] V_SC = 11'h004;
	localparam logic [10:0] V_CE = 11'h002;
	localparam logic [10:0] V_M = 11'h001;
	logic clk, rst, clr, image_xfer, mem_fitted, lun_identified, op_pending;
	logic seq_sent, seq_reconnect, atn_pin, rx_valid, tx_done, busy;
	logic [7:0] seq_code, rx_byte, ack_delay;
	stmh_phase_e atn_phase;
	logic tx_req, phase_req, status_check, resend, discard_cmd, discard_data;
	logic clear_op, sense_we, stay_connected, cmd_error, msg_taken, more_msgs;
	logic [7:0] tx_byte;
	logic [3:0] sense_key;
	stmh_phase_e phase_sel;
	logic [10:0] st;
	wire logic [10:0] pv;
	int err_total = 0;
	int n_compared = 0;
	assign pv = {tx_req, phase_req, status_check, resend, discard_cmd, discard_data,
		clear_op, sense_we, stay_connected, cmd_error, msg_taken};
	// Pulses are gathered so a one-cycle output cannot slip past a check
	always @(posedge clk) st <= clr ? pv : (st | pv);
	stmh_msg_handler u_stmh_msg_handler (.clk(clk), .rst(rst), .atn_pin(atn_pin), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .atn_phase(atn_phase), .image_xfer(image_xfer), .mem_fitted(mem_fitted),
		.lun_identified(lun_identified), .op_pending(op_pending), .seq_sent(seq_sent), .seq_code(seq_code),
		.seq_reconnect(seq_reconnect), .tx_done(tx_done), .tx_req(tx_req), .tx_byte(tx_byte),
		.phase_req(phase_req), .phase_sel(phase_sel), .status_check(status_check), .resend(resend),
		.discard_cmd(discard_cmd), .discard_data(discard_data), .clear_op(clear_op), .sense_we(sense_we),
		.sense_key(sense_key), .stay_connected(stay_connected), .cmd_error(cmd_error),
		.msg_taken(msg_taken), .more_msgs(more_msgs));
	stmh_init_model u_stmh_init_model (.clk(clk), .rst(rst), .tx_req(tx_req), .ack_delay(ack_delay),
		.tx_done(tx_done), .atn_pin(atn_pin), .rx_valid(rx_valid), .rx_byte(rx_byte), .busy(busy));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk_v(input logic [10:0] got, input logic [10:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t pulses %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic clear_st();
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
		// A stuck answer must not pass quietly
		if (busy !== 1'b0) begin
			err_total++;
			$display("MISMATCH %0t initiator model never released the byte", $time);
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic xfer(input logic [7:0] code, input logic atn, input logic [10:0] exp);
		clear_st();
		u_stmh_init_model.send(code, atn);
		wait_idle();
		chk_v(st, exp);
	endtask
	task automatic seq(input logic [7:0] code, input logic rc);
		seq_sent <= 1'b1;
		seq_code <= code;
		seq_reconnect <= rc;
		@(posedge clk);
		seq_sent <= 1'b0;
	endtask
	task automatic retry(input stmh_phase_e ph, input logic img, input logic mem,
		input stmh_phase_e eph, input logic [10:0] ev);
		atn_phase <= ph;
		image_xfer <= img;
		mem_fitted <= mem;
		xfer(MSG_INIT_ERR, 1'b0, ev);
		chk_b(tx_byte, MSG_RESTORE_PTRS);
		chk_b({5'h00, phase_sel}, {5'h00, eph});
	endtask
	task automatic t_retry();
		retry(PH_SELECTION, 1'b0, 1'b0, PH_BUS_FREE, V_T | V_P | V_M);
		retry(PH_COMMAND, 1'b0, 1'b0, PH_COMMAND, V_T | V_P | V_DC | V_M);
		retry(PH_DATA_OUT, 1'b0, 1'b0, PH_DATA_OUT, V_T | V_P | V_DD | V_M);
		retry(PH_DATA_IN, 1'b1, 1'b1, PH_DATA_IN, V_T | V_P | V_R | V_M);
		retry(PH_DATA_IN, 1'b1, 1'b0, PH_STATUS, V_T | V_P | V_S | V_SW | V_M);
		chk_b({4'h0, sense_key}, {4'h0, SENSE_ABORTED_CMD});
		retry(PH_DATA_IN, 1'b0, 1'b0, PH_DATA_IN, V_T | V_P | V_R | V_M);
		retry(PH_STATUS, 1'b0, 1'b0, PH_STATUS, V_T | V_P | V_R | V_M);
		retry(PH_MSG_IN, 1'b0, 1'b0, PH_MSG_IN, V_T | V_P | V_R | V_M);
		atn_phase <= PH_MSG_OUT;
		xfer(MSG_INIT_ERR, 1'b0, V_M);
	endtask
	task automatic t_reject();
		xfer(MSG_REJECT, 1'b0, V_P | V_M);
		seq(MSG_CMD_COMPLETE, 1'b0);
		xfer(MSG_REJECT, 1'b0, V_P | V_M);
		chk_b({5'h00, phase_sel}, {5'h00, PH_BUS_FREE});
		seq(MSG_DISCONNECT, 1'b0);
		xfer(MSG_REJECT, 1'b0, V_SC | V_M);
		seq(MSG_SAVE_PTR, 1'b0);
		xfer(MSG_REJECT, 1'b0, V_SC | V_M);
		seq(MSG_IDENTIFY_MIN, 1'b1);
		xfer(MSG_REJECT, 1'b0, V_CE | V_P | V_M);
	endtask
	task automatic t_restore_rej();
		ack_delay <= 8'h28;
		atn_phase <= PH_COMMAND;
		clear_st();
		u_stmh_init_model.send(MSG_INIT_ERR, 1'b0);
		u_stmh_init_model.send(MSG_REJECT, 1'b0);
		chk_v(st, V_T | V_P | V_S | V_M);
		chk_b({5'h00, phase_sel}, {5'h00, PH_STATUS});
		wait_idle();
		ack_delay <= 8'h02;
	endtask
	task automatic t_unsup();
		xfer(8'h01, 1'b0, V_T | V_M);
		chk_b(tx_byte, MSG_REJECT);
		xfer(MSG_REJECT, 1'b0, V_P | V_S | V_M);
	endtask
	task automatic t_abort();
		lun_identified <= 1'b1;
		op_pending <= 1'b1;
		xfer(MSG_ABORT, 1'b0, V_P | V_CO | V_M);
		lun_identified <= 1'b0;
		xfer(MSG_ABORT, 1'b0, V_P | V_M);
		lun_identified <= 1'b1;
		op_pending <= 1'b0;
		xfer(MSG_ABORT, 1'b0, V_P | V_M);
	endtask
	task automatic t_nop();
		xfer(MSG_NOP, 1'b1, V_M);
		chk_b({7'h00, more_msgs}, 8'h01);
		xfer(MSG_NOP, 1'b0, V_M);
		chk_b({7'h00, more_msgs}, 8'h00);
		// Codes owned by neighbouring logic are taken, never rejected
		xfer(MSG_PARITY_ERR, 1'b0, V_M);
		xfer(MSG_DEV_RESET, 1'b0, V_M);
		xfer(MSG_IDENTIFY_MIN, 1'b0, V_M);
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		clr = 1'b0;
		atn_phase = PH_SELECTION;
		image_xfer = 1'b0;
		mem_fitted = 1'b0;
		lun_identified = 1'b0;
		op_pending = 1'b0;
		seq_sent = 1'b0;
		seq_code = 8'h00;
		seq_reconnect = 1'b0;
		ack_delay = 8'h02;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reject();
		t_retry();
		t_restore_rej();
		t_unsup();
		t_abort();
		t_nop();
		tally_and_finish();
	end
endmodule
